// ===== verilog/dma_pkg.sv
package dma_pkg;

    // Channel count, register map and request pairs
    localparam int          NCH        = 2;
    localparam int          CHW        = 1;
    localparam int          NPICK      = 22;
    localparam int          AW         = 8;
    localparam int          SZW        = 22;
    localparam logic [4:0]  PICK_RSVD  = 5'h0b;
    localparam logic [7:0]  STATUS_OFS = 8'h30;
    localparam logic [7:0]  CLEAR_OFS  = 8'h34;
    localparam logic [7:0]  ENABLE_OFS = 8'h38;
    localparam logic [7:0]  CH_BASE    = 8'h44;
    localparam logic [7:0]  CH_STRIDE  = 8'h14;
    localparam logic [7:0]  SRC_REL    = 8'h04;
    localparam logic [7:0]  DST_REL    = 8'h08;
    localparam logic [7:0]  SIZE_REL   = 8'h0c;
    localparam int          TC_POS     = 16;
    localparam int          ERR_POS    = 0;

    // Control word fields
    localparam int          WBK_BIT    = 30;
    localparam int          LFM_BIT    = 28;
    localparam int          BURST_LO   = 24;
    localparam int          SW_LO      = 22;
    localparam int          DW_LO      = 20;
    localparam int          SMODE_BIT  = 19;
    localparam int          DMODE_BIT  = 18;
    localparam int          SSTEP_LO   = 16;
    localparam int          DSTEP_LO   = 14;
    localparam int          SPICK_LO   = 9;
    localparam int          DPICK_LO   = 4;
    localparam int          EN_BIT     = 0;
    localparam logic [31:0] CTRL_RST   = 32'h00a0_0000;
    localparam logic [1:0]  W_RSVD     = 2'h3;
    localparam logic [1:0]  STEP_INC   = 2'h0;
    localparam logic [1:0]  STEP_DEC   = 2'h1;
    localparam logic [1:0]  STEP_RSVD  = 2'h3;
    localparam logic [2:0]  WORD_BYTES = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_LEN   = 3'b010,
        ST_SRC   = 3'b011,
        ST_DST   = 3'b100,
        ST_WBK   = 3'b101,
        ST_END   = 3'b110
    } eng_st_t;

    function automatic logic [2:0] wbytes(input logic [1:0] w);
        return 3'h1 << w;
    endfunction

    function automatic logic [31:0] step_adr(input logic [31:0] a, input logic [1:0] s,
                                             input logic [2:0] b);
        if (s == STEP_INC)
            return a + 32'(b);
        else if (s == STEP_DEC)
            return a - 32'(b);
        else
            return a;
    endfunction

    function automatic logic misaligned(input logic [31:0] v, input logic [1:0] w);
        return (w == 2'h1 && v[0]) || (w == 2'h2 && v[1:0] != 2'h0);
    endfunction

    function automatic logic bad_pick(input logic [4:0] p);
        return p == PICK_RSVD || 32'(p) >= NPICK;
    endfunction

    function automatic logic [3:0] lane_sel(input logic [1:0] w, input logic [1:0] a);
        if (w == 2'h0)
            return 4'h1 << a;
        else if (w == 2'h1)
            return 4'h3 << a;
        else
            return 4'hf;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[8*i +: 8] = d[8*i +: 8];
        return r;
    endfunction

endpackage

// ===== verilog/dma_link_if.sv
`timescale 1ns/1ps
interface dma_link_if;
    logic [dma_pkg::NPICK-1:0] req;
    logic [dma_pkg::NPICK-1:0] ack;
    logic [4:0]                pick;
    logic [31:0]               rx_data;
    logic                      rx_last;
    logic [31:0]               tx_data;

    modport dma    (input req, rx_data, rx_last, output ack, pick, tx_data);
    modport periph (output req, rx_data, rx_last, input ack, pick, tx_data);
endinterface

// ===== verilog/dma_chan_end.sv
`timescale 1ns/1ps
// Summary of operation
// - Write received byte count to destination start
// - Software sets length all ones for writeback
// - Length from memory, then clear that bit
// - Otherwise software programs length before start
// - Burst of 2^k beats, then re-arbitrate
// - Burst bytes are beats times source width
// - Widths byte/half/word; code 3 is error
// - Totals not destination-aligned raise error
// - Software prefers byte destination for odd totals
// - Source flow mode: normal or handshake
// - Destination flow mode: normal or handshake
// - Stepping increment/decrement/fixed; 3 is error
// - Source pick selects pacing request pair
// - Destination pick selects pacing request pair
// - Picks 0..21 fixed pairs, 11 unused
module dma_chan_end (
    // System
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // Register bus
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [dma_pkg::AW-1:0]  wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         irq_o,
    // Memory master
    output logic                         mem_cyc_o,
    output logic                         mem_stb_o,
    output logic                         mem_we_o,
    output logic      [31:0]             mem_adr_o,
    output logic      [3:0]              mem_sel_o,
    output logic      [31:0]             mem_dat_o,
    input  wire logic [31:0]             mem_dat_i,
    input  wire logic                    mem_ack_i,
    // Peripheral link
    dma_link_if.dma                      link
);
    import dma_pkg::*;

    typedef struct packed {
        logic [NCH-1:0][31:0]    ctrl;
        logic [NCH-1:0][31:0]    src;
        logic [NCH-1:0][31:0]    dst;
        logic [NCH-1:0][SZW-1:0] size;
        logic [NCH-1:0]          tc;
        logic [NCH-1:0]          err;
        logic [NCH-1:0]          ien_tc;
        logic [NCH-1:0]          ien_err;
        logic                    ack;
        logic [31:0]             rdata;
        eng_st_t                 st;
        logic [CHW-1:0]          ch;
        logic [CHW-1:0]          rr;
        logic [7:0]              beats;
        logic [31:0]             cnt;
        logic [31:0]             data;
        logic [31:0]             dst0;
        logic                    last;
        logic                    fail;
    } state_t;

    state_t r;
    state_t next_r;

    logic [31:0]     cw;
    logic [1:0]      sw;
    logic [1:0]      dw;
    logic [1:0]      ss;
    logic [1:0]      ds;
    logic [4:0]      spick;
    logic [4:0]      dpick;
    logic            smode;
    logic            dmode;
    logic [2:0]      sbytes;
    logic [31:0]     total;
    logic [31:0]     burst;
    logic            src_hs;
    logic            dst_hs;
    logic            cfg_bad;
    logic            wr;
    logic [31:0]     status;
    logic [31:0]     ienw;
    logic [NPICK-1:0] sreq_oh;
    logic [NPICK-1:0] dreq_oh;

    // Per-channel word selected by the engine
    assign cw      = r.ctrl[r.ch];
    assign sw      = cw[SW_LO +: 2];
    assign dw      = cw[DW_LO +: 2];
    assign ss      = cw[SSTEP_LO +: 2];
    assign ds      = cw[DSTEP_LO +: 2];
    assign spick   = cw[SPICK_LO +: 5];
    assign dpick   = cw[DPICK_LO +: 5];
    assign smode   = cw[SMODE_BIT];
    assign dmode   = cw[DMODE_BIT];
    assign sbytes  = wbytes(sw);
    assign total   = 32'(r.size[r.ch]) << sw;
    assign burst   = 32'(r.beats) << sw;
    assign sreq_oh = NPICK'(1) << spick;
    assign dreq_oh = NPICK'(1) << dpick;
    assign src_hs  = r.st == ST_SRC && smode && |(link.req & sreq_oh);
    assign dst_hs  = r.st == ST_DST && dmode && |(link.req & dreq_oh);
    assign cfg_bad = sw == W_RSVD || dw == W_RSVD
                     || ss == STEP_RSVD || ds == STEP_RSVD
                     || (smode && bad_pick(spick))
                     || (dmode && bad_pick(dpick))
                     || (!cw[LFM_BIT] && (r.size[r.ch] == '0
                         || misaligned(total, dw) || misaligned(burst, dw)));
    assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack;
    assign status  = (32'(r.tc) << TC_POS) | (32'(r.err) << ERR_POS);
    assign ienw    = (32'(r.ien_tc) << TC_POS) | (32'(r.ien_err) << ERR_POS);

    // Register bus and interrupt
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign irq_o    = |(r.tc & r.ien_tc) || |(r.err & r.ien_err);

    // Memory master: held stable by the engine state until ack
    always_comb
    begin
        mem_cyc_o = r.st == ST_LEN || r.st == ST_WBK
                    || (r.st == ST_SRC && !smode) || (r.st == ST_DST && !dmode);
        mem_stb_o = mem_cyc_o;
        mem_we_o  = r.st == ST_DST || r.st == ST_WBK;
        mem_adr_o = r.st == ST_WBK ? r.dst0 : (r.st == ST_DST ? r.dst[r.ch] : r.src[r.ch]);
        mem_sel_o = (r.st == ST_LEN || r.st == ST_WBK) ? 4'hf
                    : lane_sel(sw, mem_adr_o[1:0]);
        mem_dat_o = r.st == ST_WBK ? r.cnt : r.data << {mem_adr_o[1:0], 3'h0};
    end

    // Link: pick follows the side being served; ack is the beat strobe
    assign link.pick    = r.st == ST_DST ? dpick : spick;
    assign link.ack     = src_hs ? sreq_oh : (dst_hs ? dreq_oh : '0);
    assign link.tx_data = r.data;

    always_comb
    begin
        next_r     = r;
        next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
        if (wb_cyc_i && wb_stb_i && !r.ack && !wb_we_i)
        begin
            next_r.rdata = '0;
            if (wb_adr_i == STATUS_OFS)
                next_r.rdata = status;
            else if (wb_adr_i == ENABLE_OFS)
                next_r.rdata = ienw;
            for (int c = 0; c < NCH; c++)
            begin
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c))
                    next_r.rdata = r.ctrl[c];
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + SRC_REL))
                    next_r.rdata = r.src[c];
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + DST_REL))
                    next_r.rdata = r.dst[c];
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + SIZE_REL))
                    next_r.rdata = 32'(r.size[c]);
            end
        end
        if (wr)
        begin
            if (wb_adr_i == CLEAR_OFS)
            begin
                next_r.tc  = r.tc & ~wb_dat_i[TC_POS +: NCH];
                next_r.err = r.err & ~wb_dat_i[ERR_POS +: NCH];
            end
            else if (wb_adr_i == ENABLE_OFS)
            begin
                // Unselected lanes keep the old enables, not the status bits
                next_r.ien_tc  = NCH'(merge(ienw, wb_dat_i, wb_sel_i) >> TC_POS);
                next_r.ien_err = NCH'(merge(ienw, wb_dat_i, wb_sel_i) >> ERR_POS);
            end
            for (int c = 0; c < NCH; c++)
            begin
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c))
                    next_r.ctrl[c] = merge(r.ctrl[c], wb_dat_i, wb_sel_i);
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + SRC_REL))
                    next_r.src[c] = merge(r.src[c], wb_dat_i, wb_sel_i);
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + DST_REL))
                    next_r.dst[c] = merge(r.dst[c], wb_dat_i, wb_sel_i);
                if (wb_adr_i == AW'(CH_BASE + CH_STRIDE * c + SIZE_REL))
                    next_r.size[c] = SZW'(merge(32'(r.size[c]), wb_dat_i, wb_sel_i));
            end
        end

        // Engine updates come last so hardware sets beat software clears
        unique case (r.st)
            ST_IDLE:
            begin
                for (int i = NCH - 1; i >= 0; i--)
                    if (r.ctrl[CHW'(r.rr + CHW'(i))][EN_BIT])
                        next_r.ch = CHW'(r.rr + CHW'(i));
                // Stay idle when nothing is enabled, so a finished channel does not rerun
                if (r.ctrl[next_r.ch][EN_BIT])
                begin
                    next_r.st    = ST_CHECK;
                    next_r.rr    = CHW'(next_r.ch + CHW'(1));
                    next_r.beats = 8'h1 << r.ctrl[next_r.ch][BURST_LO +: 3];
                end
            end
            ST_CHECK:
            begin
                next_r.fail = cfg_bad;
                if (cfg_bad)
                    next_r.st = ST_END;
                else if (cw[LFM_BIT])
                    next_r.st = ST_LEN;
                else
                    next_r.st = ST_SRC;
                if (r.cnt == '0 && !cfg_bad)
                    next_r.dst0 = r.dst[r.ch];
            end
            ST_LEN:
                if (mem_ack_i)
                begin
                    next_r.size[r.ch]         = mem_dat_i[SZW-1:0];
                    next_r.ctrl[r.ch][LFM_BIT] = 1'b0;
                    next_r.src[r.ch]          = step_adr(r.src[r.ch], ss, WORD_BYTES);
                    next_r.st                 = ST_CHECK;
                end
            ST_SRC:
                if (src_hs || (!smode && mem_ack_i))
                begin
                    next_r.data = smode ? link.rx_data
                                        : mem_dat_i >> {mem_adr_o[1:0], 3'h0};
                    next_r.last = smode && link.rx_last;
                    next_r.src[r.ch] = step_adr(r.src[r.ch], ss, sbytes);
                    next_r.st   = ST_DST;
                end
            ST_DST:
                if (dst_hs || (!dmode && mem_ack_i))
                begin
                    next_r.dst[r.ch]  = step_adr(r.dst[r.ch], ds, sbytes);
                    next_r.cnt        = r.cnt + 32'(sbytes);
                    next_r.size[r.ch] = r.size[r.ch] - SZW'(1);
                    next_r.beats      = r.beats - 8'h1;
                    if (r.size[r.ch] == SZW'(1) || r.last)
                        next_r.st = (cw[WBK_BIT] && smode) ? ST_WBK : ST_END;
                    else if (r.beats == 8'h1)
                        next_r.st = ST_IDLE;
                    else
                        next_r.st = ST_SRC;
                end
            ST_WBK:
                if (mem_ack_i)
                    next_r.st = ST_END;
            ST_END:
            begin
                next_r.ctrl[r.ch][EN_BIT] = 1'b0;
                if (r.fail)
                    next_r.err[r.ch] = 1'b1;
                else
                begin
                    next_r.tc[r.ch]   = 1'b1;
                    next_r.size[r.ch] = '0;
                end
                next_r.cnt  = '0;
                next_r.last = 1'b0;
                next_r.fail = 1'b0;
                next_r.st   = ST_IDLE;
            end
            default:
                next_r.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            r      <= '0;
            r.ctrl <= {NCH{CTRL_RST}};
            r.st   <= ST_IDLE;
        end
        else
            r <= next_r;
    end

endmodule // dma_chan_end

// ===== verilog/dma_periph_end.sv
`timescale 1ns/1ps
module dma_periph_end (
    // System
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    // User side
    input  wire logic [dma_pkg::NPICK-1:0] push_i,
    input  wire logic [31:0]               push_data_i,
    input  wire logic                      push_last_i,
    output logic      [dma_pkg::NPICK-1:0] push_ready_o,
    output logic      [dma_pkg::NPICK-1:0] done_o,
    output logic      [31:0]               got_data_o,
    // Peripheral link
    dma_link_if.periph                     link
);
    import dma_pkg::*;

    typedef struct packed {
        logic [NPICK-1:0]        req;
        logic [NPICK-1:0][31:0]  data;
        logic [NPICK-1:0]        last;
        logic [NPICK-1:0]        done;
        logic [31:0]             got;
    } pstate_t;

    pstate_t r;
    pstate_t next_r;

    assign push_ready_o = ~r.req;
    assign done_o       = r.done;
    assign got_data_o   = r.got;
    assign link.req     = r.req;
    // Pick beyond the pair table reads as zero
    assign link.rx_data = 32'(link.pick) < NPICK ? r.data[link.pick] : '0;
    assign link.rx_last = 32'(link.pick) < NPICK ? r.last[link.pick] : 1'b0;

    always_comb
    begin
        next_r      = r;
        next_r.done = link.ack & r.req;
        // Request held with its data until the channel acknowledges it
        for (int k = 0; k < NPICK; k++)
        begin
            if (link.ack[k] && r.req[k])
            begin
                next_r.req[k] = 1'b0;
                next_r.got    = link.tx_data;
            end
            if (push_i[k] && !r.req[k])
            begin
                next_r.req[k]  = 1'b1;
                next_r.data[k] = push_data_i;
                next_r.last[k] = push_last_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            r <= '0;
        else
            r <= next_r;
    end

endmodule // dma_periph_end

// ===== sim/dma_link_properties.sv
`timescale 1ns/1ps
module dma_link_properties (
    // System
    input wire logic                      clk_i,
    input wire logic                      sys_rst_i,
    // Link
    input wire logic [dma_pkg::NPICK-1:0] req_i,
    input wire logic [dma_pkg::NPICK-1:0] ack_i,
    input wire logic [4:0]                pick_i
);
    import dma_pkg::*;

    // Lines asking and not yet answered, one cycle back
    logic [NPICK-1:0] waiting;

    always_ff @(posedge clk_i)
    begin
        waiting <= req_i & ~ack_i;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_taken;
        ack_i != '0;
    endsequence

    sequence s_released;
        (req_i & $past(ack_i)) == '0;
    endsequence

    a_ack_onehot: assert property ($onehot0(ack_i))
        else $error("link ack on more than one line");
    a_ack_needs_req: assert property (s_taken |-> (ack_i & ~req_i) == '0)
        else $error("link ack without request");
    a_ack_on_pick: assert property (s_taken |-> ack_i[pick_i])
        else $error("link ack not on picked line");
    a_pick_not_rsvd: assert property (s_taken |-> pick_i != PICK_RSVD)
        else $error("link ack on unused pick");
    a_pick_in_range: assert property (s_taken |-> 32'(pick_i) < NPICK)
        else $error("link ack on pick out of range");
    a_req_drops: assert property (s_taken |=> s_released)
        else $error("request stays up after ack");
    a_ack_quiet: assert property (s_taken |=> (ack_i & $past(ack_i)) == '0)
        else $error("same line acked twice in a row");
    a_req_holds: assert property (waiting != '0 |-> (req_i & waiting) == waiting)
        else $error("request withdrawn before ack");

    c_handshake: cover property (s_taken ##1 s_released);
endmodule // dma_link_properties

// ===== sim/tb_dma_channel_control.sv
`timescale 1ns/1ps
module tb_dma_channel_control;
    import dma_pkg::*;

    logic             clk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic             wb_cyc = 1'b0;
    logic             wb_stb = 1'b0;
    logic             wb_we = 1'b0;
    logic [AW-1:0]    wb_adr = '0;
    logic [31:0]      wb_dat = '0;
    logic [31:0]      wb_q, mem_adr, mem_dat, got, q;
    logic [31:0]      mem_q = '0;
    logic [31:0]      push_data = '0;
    logic             push_last = 1'b0;
    logic             mem_ack = 1'b0;
    logic             wb_ack, irq, mem_cyc, mem_stb, mem_we;
    logic [3:0]       mem_sel;
    logic [NPICK-1:0] push = '0;
    logic [NPICK-1:0] ready;
    logic [NPICK-1:0] done;
    logic [31:0]      mem [64];
    int               miscompares = 0;
    int               n_checks = 0;
    int               cycles = 0;

    dma_link_if lnk ();

    dma_chan_end i_dma_chan_end (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .irq_o(irq), .mem_cyc_o(mem_cyc),
        .mem_stb_o(mem_stb), .mem_we_o(mem_we), .mem_adr_o(mem_adr), .mem_sel_o(mem_sel),
        .mem_dat_o(mem_dat), .mem_dat_i(mem_q), .mem_ack_i(mem_ack), .link(lnk));

    dma_periph_end i_dma_periph_end (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .push_i(push), .push_data_i(push_data),
        .push_last_i(push_last), .push_ready_o(ready), .done_o(done), .got_data_o(got),
        .link(lnk));

    dma_link_properties i_dma_link_properties (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(lnk.req), .ack_i(lnk.ack),
        .pick_i(lnk.pick));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    // Memory answers a cycle late; idle data toggles so stale values never pass
    always @(posedge clk_i)
    begin
        if (mem_cyc && mem_stb && !mem_ack)
        begin
            mem_ack <= 1'b1;
            mem_q <= mem[mem_adr[7:2]];
            for (int i = 0; i < 4; i++)
                if (mem_we && mem_sel[i])
                    mem[mem_adr[7:2]][8*i +: 8] <= mem_dat[8*i +: 8];
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_q <= ~mem_q;
        end
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do
            @(posedge clk_i);
        while (wb_ack !== 1'b1);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    function automatic logic [31:0] cw(input int b, sw, dw, sm, dm, ss, ds, sp, dp);
        return 32'(b) << BURST_LO | 32'(sw) << SW_LO | 32'(dw) << DW_LO
            | 32'(sm) << SMODE_BIT | 32'(dm) << DMODE_BIT | 32'(ss) << SSTEP_LO
            | 32'(ds) << DSTEP_LO | 32'(sp) << SPICK_LO | 32'(dp) << DPICK_LO | 32'h1;
    endfunction

    task automatic run(input int ch, input logic [31:0] c, s, d, z);
        logic [7:0] b;
        b = CH_BASE + 8'(ch) * CH_STRIDE;
        wb(1, b + SRC_REL, s);
        wb(1, b + DST_REL, d);
        wb(1, b + SIZE_REL, z);
        wb(1, b, c);
        for (int n = 0; n < 3000 && irq !== 1'b1; n++)
            @(posedge clk_i);
        chk("irq raised", 1, irq);
        wb(0, STATUS_OFS, 0);
    endtask

    task automatic clear();
        wb(1, CLEAR_OFS, 32'hffff_ffff);
        wb(0, STATUS_OFS, 0);
        chk("status cleared", 0, q);
        chk("irq low", 0, irq);
    endtask

    // Peripheral asks once on a line and waits for the engine to answer
    task automatic pushw(input int l, input logic [31:0] d, input logic last);
        int n;
        n = 0;
        @(posedge clk_i);
        push[l] <= 1'b1;
        push_data <= d;
        push_last <= last;
        @(posedge clk_i);
        push[l] <= 1'b0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ready[l] !== 1'b1 && n < 3000);
        // Done pulses in the same cycle that the line frees up
        chk("done pulse", 1, 32'(done[l]));
    endtask

    task automatic t_reset();
        chk("ready after reset", 32'h003f_ffff, 32'(ready));
        wb(0, CH_BASE, 0);
        chk("ctrl0 reset", CTRL_RST, q);
        wb(1, CH_BASE + CH_STRIDE, 32'h00a0_1230);
        wb(0, CH_BASE + CH_STRIDE, 0);
        chk("ctrl1 rw", 32'h00a0_1230, q);
        wb(0, CH_BASE, 0);
        chk("ctrl0 apart", CTRL_RST, q);
        wb(0, 8'h3c, 0);
        chk("unmapped read", 0, q);
        wb(1, ENABLE_OFS, 32'h0003_0003);
    endtask

    task automatic t_word();
        mem[4] = 32'hcafe_0001;
        mem[5] = 32'hcafe_0002;
        run(1, cw(0, 2, 2, 0, 0, 0, 1, 0, 0), 32'h10, 32'h2c, 2);
        chk("word status", 32'h0002_0000, q);
        chk("first word", 32'hcafe_0001, mem[11]);
        chk("second word down", 32'hcafe_0002, mem[10]);
        wb(0, CH_BASE + CH_STRIDE + SIZE_REL, 0);
        chk("size at end", 0, q);
        wb(1, ENABLE_OFS, 0);
        @(posedge clk_i);
        chk("irq masked", 0, irq);
        wb(1, ENABLE_OFS, 32'h0003_0003);
        @(posedge clk_i);
        chk("irq unmasked", 1, irq);
        clear();
    endtask

    task automatic t_byte();
        mem[16] = 32'h4433_2211;
        mem[32] = 32'ha5a5_a5a5;
        run(0, cw(2, 0, 0, 0, 0, 0, 2, 0, 0), 32'h40, 32'h80, 3);
        chk("byte status", 32'h0001_0000, q);
        chk("fixed byte dest", 32'ha5a5_a533, mem[32]);
        clear();
        // Half-word from upper lanes, source stepping down
        mem[17] = 32'h7788_6655;
        run(0, cw(0, 1, 1, 0, 0, 1, 0, 0, 0), 32'h46, 32'h90, 1);
        chk("half status", 32'h0001_0000, q);
        chk("half lanes", 32'h2424_7788, mem[36]);
        wb(0, CH_BASE + SRC_REL, 0);
        chk("source stepped down", 32'h0000_0044, q);
        clear();
    endtask

    task automatic t_err();
        logic [31:0] c [10];
        logic [31:0] z [10];
        c = '{cw(0, 3, 2, 0, 0, 0, 0, 0, 0), cw(0, 2, 3, 0, 0, 0, 0, 0, 0),
              cw(0, 2, 2, 0, 0, 3, 0, 0, 0), cw(0, 2, 2, 0, 0, 0, 3, 0, 0),
              cw(0, 2, 2, 1, 0, 2, 0, 11, 0), cw(0, 2, 2, 1, 0, 2, 0, 22, 0),
              cw(0, 2, 2, 0, 1, 0, 2, 0, 11), cw(0, 2, 2, 0, 0, 0, 0, 0, 0),
              cw(0, 0, 2, 0, 0, 0, 0, 0, 0), cw(0, 0, 1, 0, 0, 0, 0, 0, 0)};
        z = '{4, 4, 4, 4, 4, 4, 4, 0, 3, 2};
        for (int i = 0; i < 10; i++)
        begin
            run(0, c[i], 0, 32'h80, z[i]);
            chk("error status", 32'h0000_0001, q);
            clear();
        end
    endtask

    task automatic t_wbk();
        mem[48] = 32'h5a5a_5a5a;
        fork
            run(0, cw(0, 2, 2, 1, 0, 2, 0, 3, 0) | 32'h4000_0000, 0, 32'hc0, 32'h00ff_ffff);
            begin
                pushw(3, 32'h1111_1111, 0);
                pushw(3, 32'h2222_2222, 1);
            end
        join
        chk("rx status", 32'h0001_0000, q);
        chk("byte count stored", 32'h0000_0008, mem[48]);
        clear();
    endtask

    task automatic t_lfm();
        mem[24] = 32'h0000_0002;
        mem[25] = 32'hbeef_0001;
        mem[26] = 32'hbeef_0002;
        fork
            run(1, cw(0, 2, 2, 0, 1, 0, 2, 0, 4) | 32'h1000_0000, 32'h60, 0, 0);
            begin
                pushw(4, 0, 0);
                pushw(4, 0, 0);
            end
        join
        chk("tx status", 32'h0002_0000, q);
        chk("last sent word", 32'hbeef_0002, got);
        wb(0, CH_BASE + CH_STRIDE, 0);
        chk("length flag", 0, 32'(q[LFM_BIT]));
        clear();
    endtask

    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 32'(i) * 32'h0101_0101;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_word();
        t_byte();
        t_err();
        t_wbk();
        t_lfm();
        end_of_test();
    end
endmodule // tb_dma_channel_control
